// >>> tb/cmbt_engine_model.sv
// Behavioural stand-in for the protocol engine and the bus traffic behind it.
// Assumes the bench steers it on the rising edge of the core clock.
module cmbt_engine_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       abort_in,
  input  wire logic       pend_cmd_in,
  input  wire logic [3:0] abort_delay_in,
  input  wire logic       idle_cmd_in,
  input  wire logic       rx_cmd_in,
  input  wire logic [7:0] tx_cnt_in,
  input  wire logic [7:0] rx_cnt_in,
  output logic            device_idle_out,
  output logic            tx_pending_out,
  output logic            rx_msg_done_out,
  output logic [7:0]      tx_count_out,
  output logic [7:0]      rx_count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;  // Cycles of abort still needed before buffers empty, less one.
  logic       rx_q;  // Delayed receive command, for edge detection.
  assign device_idle_out = idle_cmd_in;
  // Pending buffers drain only after the abort has been held a while.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_pending_out <= 1'b0;
      left <= 4'h0;
      rx_q <= 1'b0;
      rx_msg_done_out <= 1'b0;
      tx_count_out <= 8'h00;
      rx_count_out <= 8'h00;
    end else begin
      rx_q <= rx_cmd_in;
      rx_msg_done_out <= rx_cmd_in & ~rx_q;
      tx_count_out <= tx_cnt_in;
      rx_count_out <= rx_cnt_in;
      if (pend_cmd_in) begin
        tx_pending_out <= 1'b1;
        left <= abort_delay_in;
      end else if (abort_in && tx_pending_out) begin
        if (left == 4'h0) tx_pending_out <= 1'b0;
        else left <= left - 4'h1;
      end
    end
  end
endmodule  // cmbt_engine_model

// >>> tb/test_can_mode_and_bit_timing_control.sv
// Self-checking bench for the CAN mode and bit-timing control block.
// Assumes the design, its package and the constants header are compiled first.
`include "cmbt_defs.svh"
module test_can_mode_and_bit_timing_control;
  timeunit 1ns;
  timeprecision 1ps;
  import cmbt_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_last;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, resync_jump_width;
  logic pend = 1'b0, idle = 1'b0, rxc = 1'b0, dev_idle, pending, rx_done;
  logic [7:0] txc = 8'h00, rxn = 8'h00, txe, rxe;
  logic abort, halted, trig, win, tick, irq;
  cmbt_mode_t cur;
  int errors = 0, cmp_count = 0, n;
  always #5 core_clk = ~core_clk;
  cmbt_mode_timing dut_u (.core_clk_in(core_clk), .rst_n_in(rst_n), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .device_idle_in(dev_idle), .tx_pending_in(pending),
    .rx_msg_done_in(rx_done), .tx_error_counter_in(txe), .rx_error_counter_in(rxe),
    .current_mode_out(cur), .abort_all_transmits_out(abort), .module_halted_out(halted),
    .rx_capture_trigger_out(trig), .filter_window_out(win), .resync_jump_width_out(resync_jump_width),
    .time_quantum_tick_out(tick), .irq_out(irq));
  cmbt_engine_model far_u (.clk_in(core_clk), .rst_n_in(rst_n), .abort_in(abort),
    .pend_cmd_in(pend), .abort_delay_in(4'h5), .idle_cmd_in(idle), .rx_cmd_in(rxc),
    .tx_cnt_in(txc), .rx_cnt_in(rxn), .device_idle_out(dev_idle),
    .tx_pending_out(pending), .rx_msg_done_out(rx_done), .tx_count_out(txe),
    .rx_count_out(rxe));
  // Reports and counts one comparison.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits for ready high at a settled point, then passes the sampling edge.
  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge core_clk);
    while (hready !== 1'b1 && k < 50) begin
      k++;
      @(negedge core_clk);
    end
    if (k == 50) begin
      errors++;
      print_verdict();
    end
    rd_last = hrdata;
    @(posedge core_clk);
  endtask
  // One single word transfer; read data ends up in rd_last.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
  endtask
  // Raises a receive and counts capture pulses seen over six cycles.
  task automatic rx_event(output int c);
    rxc <= 1'b1;
    c = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (trig === 1'b1) c++;
    end
    @(posedge core_clk);
    rxc <= 1'b0;
    @(posedge core_clk);
  endtask
  // Measures cycles between two quantum ticks.
  task automatic period(output int p);
    p = 0;
    @(negedge core_clk);
    while (tick !== 1'b1 && p < 300) begin
      p++;
      @(negedge core_clk);
    end
    p = 0;
    do begin
      p++;
      @(negedge core_clk);
    end while (tick !== 1'b1 && p < 300);
    @(posedge core_clk);
  endtask
  // Ends the run with the counts and the verdict.
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // The watchdog stops a hung run well past the expected length.
  initial begin
    #200000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(`CMBT_OFS_CTRL, 1'b0, 32'h0);
    check(rd_last, 32'h0000_0480);
    bus(`CMBT_OFS_ERRCNT, 1'b0, 32'h0);
    check(rd_last, 32'h0);
    bus(8'h20, 1'b0, 32'h0);
    check(rd_last, 32'h0);
    $display("Reset values done");
    for (int i = 0; i < 8; i++) begin
      logic [2:0] m;
      m = (i < 4) ? 3'(i) : (i == 4) ? 3'h7 : (i == 5) ? 3'h4 : 3'(i - 1);
      bus(`CMBT_OFS_CTRL, 1'b1, {21'h0, m, 8'h00});
      bus(`CMBT_OFS_CTRL, 1'b0, 32'h0);
      check(rd_last[7:5], (i < 6) ? m : 3'h4);
    end
    $display("Mode codes done");
    txc <= 8'hA5;
    rxn <= 8'h3C;
    bus(`CMBT_OFS_ERRCNT, 1'b1, 32'hFFFF);
    bus(`CMBT_OFS_ERRCNT, 1'b0, 32'h0);
    check(rd_last, 32'h0000_A53C);
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_0409);
    @(negedge core_clk);
    check(win, 1'b1);
    @(posedge core_clk);
    rx_event(n);
    check(n, 1);
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_0400);
    @(negedge core_clk);
    check(win, 1'b0);
    @(posedge core_clk);
    rx_event(n);
    check(n, 0);
    $display("Window and capture done");
    bus(`CMBT_OFS_STATUS, 1'b0, 32'h0);
    bus(`CMBT_OFS_MASK, 1'b1, 32'h4);
    rx_event(n);
    check(irq, 1'b1);
    bus(`CMBT_OFS_STATUS, 1'b0, 32'h0);
    check(rd_last, 32'h4);
    check(irq, 1'b0);
    bus(`CMBT_OFS_MASK, 1'b1, 32'h0);
    rx_event(n);
    check(irq, 1'b0);
    $display("Interrupt done");
    pend <= 1'b1;
    @(posedge core_clk);
    pend <= 1'b0;
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_1400);
    n = 0;
    @(negedge core_clk);
    check(abort, 1'b1);
    while (abort === 1'b1 && n < 40) begin
      n++;
      @(negedge core_clk);
    end
    @(posedge core_clk);
    check(n >= 4 && n < 40, 1'b1);
    bus(`CMBT_OFS_STATUS, 1'b0, 32'h0);
    check(rd_last[1], 1'b1);
    $display("Abort done");
    idle <= 1'b1;
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_2200);
    @(negedge core_clk);
    check(halted, 1'b1);
    @(posedge core_clk);
    bus(`CMBT_OFS_CTRL, 1'b0, 32'h0);
    check(rd_last[7:5], 3'h4);
    idle <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(halted, 1'b0);
    bus(`CMBT_OFS_CTRL, 1'b0, 32'h0);
    check(rd_last[7:5], 3'h2);
    $display("Idle stop done");
    bus(`CMBT_OFS_TIMING, 1'b1, 32'h0000_00C1);
    bus(`CMBT_OFS_TIMING, 1'b0, 32'h0);
    check(rd_last, 32'h0000_00C1);
    check(resync_jump_width, 3'h4);
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_0800);
    period(n);
    check(n, 4);
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_0000);
    period(n);
    check(n, 8);
    bus(`CMBT_OFS_TIMING, 1'b1, 32'h0000_003F);
    bus(`CMBT_OFS_CTRL, 1'b1, 32'h0000_0800);
    check(resync_jump_width, 3'h1);
    period(n);
    check(n, 128);
    $display("Bit timing done");
    print_verdict();
  end
endmodule  // test_can_mode_and_bit_timing_control

// >>> verilog/cmbt_defs.svh
// Register offsets, field positions, reset values and widths of the CAN mode
// and bit-timing control block, as `define macros.
// Assumes inclusion by bare name from the bench and the design file.
// Overview of operation
// - Idle stop bit halts module during device idle.
// - Abort bit aborts transmits; hardware clears when done.
// - Clock select: protocol clock twice peripheral clock.
// - Mode request codes; 101 and 110 reserved.
// - Current mode readback, resets to Configuration.
// - Capture enable triggers timer capture on receive.
// - Window bit selects filter or buffer map.
// - Transmit error count in bits 15-8.
`ifndef CMBT_DEFS_SVH
`define CMBT_DEFS_SVH
// Byte offsets of the registers on the bus.
`define CMBT_OFS_CTRL      8'h00
`define CMBT_OFS_ERRCNT    8'h04
`define CMBT_OFS_TIMING    8'h08
`define CMBT_OFS_STATUS    8'h0C
`define CMBT_OFS_MASK      8'h10
// Control register field positions.
`define CMBT_BIT_IDLE_STOP 13
`define CMBT_BIT_ABORT     12
`define CMBT_BIT_CLK_SEL   11
`define CMBT_REQ_HI        10
`define CMBT_REQ_LO        8
`define CMBT_CUR_HI        7
`define CMBT_CUR_LO        5
`define CMBT_BIT_CAPTURE   3
`define CMBT_BIT_WINDOW    0
// Timing register field positions.
`define CMBT_SJW_HI        7
`define CMBT_SJW_LO        6
`define CMBT_BRP_HI        5
`define CMBT_BRP_LO        0
// Interrupt status and mask bit positions.
`define CMBT_IRQ_MODE      0
`define CMBT_IRQ_ABORT     1
`define CMBT_IRQ_RX        2
`define CMBT_IRQ_W         3
// Reset values.
`define CMBT_RST_MODE      3'h4
`define CMBT_RST_TIMING    8'h00
`endif

// >>> verilog/cmbt_mode_timing.sv
// Control, status and bit-timing registers of a CAN controller.
// Assumes an AHB-Lite master on core_clk_in, and protocol-engine signals
// (idle, pending transmits, receive strobe, error counts) on the same clock.
// The core clock stands for twice the peripheral clock.
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "cmbt_defs.svh"
module cmbt_mode_timing (
  input  wire logic               core_clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               hsel_in,
  input  wire logic [31:0]        haddr_in,
  input  wire logic [1:0]         htrans_in,
  input  wire logic               hwrite_in,
  input  wire logic [2:0]         hsize_in,
  input  wire logic [31:0]        hwdata_in,
  input  wire logic               hready_in,
  output logic [31:0]             hrdata_out,
  output logic                    hreadyout_out,
  output logic                    hresp_out,
  input  wire logic               device_idle_in,
  input  wire logic               tx_pending_in,
  input  wire logic               rx_msg_done_in,
  input  wire logic [7:0]         tx_error_counter_in,
  input  wire logic [7:0]         rx_error_counter_in,
  output cmbt_pkg::cmbt_mode_t    current_mode_out,
  output logic                    abort_all_transmits_out,
  output logic                    module_halted_out,
  output logic                    rx_capture_trigger_out,
  output logic                    filter_window_out,
  output logic [2:0]              resync_jump_width_out,
  output logic                    time_quantum_tick_out,
  output logic                    irq_out
);
  import cmbt_pkg::*;

  cmbt_ctrl_t          ctrl, next_ctrl;         // Control register fields.
  cmbt_mode_t          cur_mode, next_cur_mode; // Mode the module is in.
  cmbt_ahb_ph_t        ph, next_ph;             // Pending bus data phase.
  logic                rd_wait, next_rd_wait;   // Read wait state taken.
  logic [31:0]         rdata, next_rdata;       // Read data register.
  logic [7:0]          timing, next_timing;     // Jump width and prescaler.
  logic [15:0]         errcnt, next_errcnt;     // Error count snapshot.
  logic [`CMBT_IRQ_W-1:0] stat, next_stat;      // Sticky event bits.
  logic [`CMBT_IRQ_W-1:0] mask, next_mask;      // Interrupt mask.
  logic                half, next_half;         // Peripheral clock phase.
  logic [6:0]          tq_cnt, next_tq_cnt;     // Protocol ticks in quantum.
  logic                tq_tick, next_tq_tick;   // Quantum boundary strobe.
  logic                cap, next_cap;           // Capture strobe.
  logic                halted;                  // Stopped during idle.
  logic                ptick;                   // Protocol clock tick.
  logic                wr_ph;                   // Write data phase now.
  logic                rd_go;                   // Read data sampled now.
  logic [6:0]          tq_len;                  // Last tick index of a quantum.
  logic [`CMBT_IRQ_W-1:0] ev;                   // Events this cycle.

  // True for the six defined mode codes.
  function automatic logic mode_legal(input cmbt_mode_t m);
    return (m != CMBT_RSVD_5) && (m != CMBT_RSVD_6);
  endfunction

  // Register read multiplexer; unmapped offsets read as zero.
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    read_mux = 32'h0000_0000;
    unique case (a)
      `CMBT_OFS_CTRL: begin
        read_mux[`CMBT_BIT_IDLE_STOP] = ctrl.idle_stop_enable;
        read_mux[`CMBT_BIT_ABORT] = ctrl.abort_all_transmits;
        read_mux[`CMBT_BIT_CLK_SEL] = ctrl.protocol_clock_select;
        read_mux[`CMBT_REQ_HI:`CMBT_REQ_LO] = ctrl.mode_request;
        read_mux[`CMBT_CUR_HI:`CMBT_CUR_LO] = cur_mode;
        read_mux[`CMBT_BIT_CAPTURE] = ctrl.rx_timestamp_capture_enable;
        read_mux[`CMBT_BIT_WINDOW] = ctrl.window_select;
      end
      `CMBT_OFS_ERRCNT: read_mux[15:0] = errcnt;
      `CMBT_OFS_TIMING: read_mux[7:0] = timing;
      `CMBT_OFS_STATUS: read_mux[`CMBT_IRQ_W-1:0] = stat;
      `CMBT_OFS_MASK:   read_mux[`CMBT_IRQ_W-1:0] = mask;
      default:          read_mux = 32'h0000_0000;
    endcase
  endfunction

  // Slave answers: writes without wait, reads with one wait state.
  assign wr_ph = ph.valid & ph.write;
  assign rd_go = ph.valid & ~ph.write & ~rd_wait;
  assign hreadyout_out = ~rd_go;
  assign hresp_out = 1'b0;

  // Idle halt and protocol clock derivation.
  assign halted = ctrl.idle_stop_enable & device_idle_in;
  assign ptick = ~halted & (ctrl.protocol_clock_select | half);
  // The last index 2*(prescaler+1)-1 is the prescaler with a one appended.
  // The largest prescaler then still fits in seven bits without overflow.
  assign tq_len = {timing[`CMBT_BRP_HI:`CMBT_BRP_LO], 1'b1};

  // Next-state logic for bus, control, mode, timing and events.
  always_comb begin
    next_ctrl = ctrl;
    next_cur_mode = cur_mode;
    next_ph = ph;
    next_rd_wait = rd_go;
    next_rdata = rdata;
    next_timing = timing;
    next_mask = mask;
    next_cap = 1'b0;
    next_tq_tick = 1'b0;
    next_tq_cnt = tq_cnt;
    next_half = halted ? 1'b0 : ~half;
    ev = '0;
    // Counters are presented as a snapshot of the protocol engine.
    next_errcnt = {tx_error_counter_in, rx_error_counter_in};
    // Address phase capture, held while the slave stalls.
    if (hready_in) begin
      next_ph.valid = hsel_in & htrans_in[1];
      next_ph.write = hwrite_in;
      next_ph.addr = haddr_in[7:0];
    end
    // Read data sampled in the wait cycle.
    if (rd_go) begin
      next_rdata = read_mux(ph.addr);
    end
    // Hardware clears abort once no transmit remains pending.
    if (ctrl.abort_all_transmits && !tx_pending_in) begin
      next_ctrl.abort_all_transmits = 1'b0;
      ev[`CMBT_IRQ_ABORT] = 1'b1;
    end
    // Mode follows a legal request unless halted; reserved codes ignored.
    if (!halted && mode_legal(ctrl.mode_request) && cur_mode != ctrl.mode_request) begin
      next_cur_mode = ctrl.mode_request;
      ev[`CMBT_IRQ_MODE] = 1'b1;
    end
    // Receive strobe raises capture when enabled.
    if (rx_msg_done_in && !halted) begin
      next_cap = ctrl.rx_timestamp_capture_enable;
      ev[`CMBT_IRQ_RX] = 1'b1;
    end
    // Time quantum counter on protocol clock ticks.
    if (ptick) begin
      if (tq_cnt >= tq_len) begin
        next_tq_cnt = 7'h00;
        next_tq_tick = 1'b1;
      end else begin
        next_tq_cnt = tq_cnt + 7'h01;
      end
    end
    // Register writes in the data phase; a software set of abort wins.
    if (wr_ph) begin
      unique case (ph.addr)
        `CMBT_OFS_CTRL: begin
          next_ctrl.idle_stop_enable = hwdata_in[`CMBT_BIT_IDLE_STOP];
          if (hwdata_in[`CMBT_BIT_ABORT]) begin
            next_ctrl.abort_all_transmits = 1'b1;
          end
          next_ctrl.protocol_clock_select = hwdata_in[`CMBT_BIT_CLK_SEL];
          next_ctrl.mode_request = cmbt_mode_t'(hwdata_in[`CMBT_REQ_HI:`CMBT_REQ_LO]);
          next_ctrl.rx_timestamp_capture_enable = hwdata_in[`CMBT_BIT_CAPTURE];
          next_ctrl.window_select = hwdata_in[`CMBT_BIT_WINDOW];
        end
        `CMBT_OFS_TIMING: next_timing = hwdata_in[7:0];
        `CMBT_OFS_MASK:   next_mask = hwdata_in[`CMBT_IRQ_W-1:0];
        default:          next_timing = timing;
      endcase
    end
    // Reading status clears it; an event in the same cycle survives.
    next_stat = ((rd_go && ph.addr == `CMBT_OFS_STATUS) ? '0 : stat) | ev;
  end

  // State registers.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl <= '{mode_request: CMBT_CONFIG, default: 1'b0};
      cur_mode <= CMBT_CONFIG;
      ph <= '0;
      rd_wait <= 1'b0;
      rdata <= 32'h0000_0000;
      timing <= `CMBT_RST_TIMING;
      errcnt <= 16'h0000;
      stat <= '0;
      mask <= '0;
      half <= 1'b0;
      tq_cnt <= 7'h00;
      tq_tick <= 1'b0;
      cap <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      cur_mode <= next_cur_mode;
      ph <= next_ph;
      rd_wait <= next_rd_wait;
      rdata <= next_rdata;
      timing <= next_timing;
      errcnt <= next_errcnt;
      stat <= next_stat;
      mask <= next_mask;
      half <= next_half;
      tq_cnt <= next_tq_cnt;
      tq_tick <= next_tq_tick;
      cap <= next_cap;
    end
  end

  // Outputs, all from registers except the halt flag, which also follows device_idle_in.
  assign hrdata_out = rdata;
  assign current_mode_out = cur_mode;
  assign abort_all_transmits_out = ctrl.abort_all_transmits;
  assign module_halted_out = halted;
  assign rx_capture_trigger_out = cap;
  assign filter_window_out = ctrl.window_select;
  assign resync_jump_width_out = {1'b0, timing[`CMBT_SJW_HI:`CMBT_SJW_LO]} + 3'h1;
  assign time_quantum_tick_out = tq_tick;
  assign irq_out = |(stat & mask);

  // Checks on the block's own behaviour.
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // A halted cycle launches no quantum tick into the next cycle.
  AST_IDLE_HALT: assert property (halted |=> !time_quantum_tick_out)
    else $error("Quantum tick while halted in idle.");
  AST_ABORT_CLR: assert property (
    ctrl.abort_all_transmits && !tx_pending_in && !wr_ph |=> !abort_all_transmits_out)
    else $error("Abort bit not cleared after transmits ended.");
  AST_ABORT_SET: assert property (
    wr_ph && ph.addr == `CMBT_OFS_CTRL && hwdata_in[`CMBT_BIT_ABORT]
    |=> abort_all_transmits_out)
    else $error("Abort write lost.");
  // A register write may change the clock select, so such cycles are left out.
  AST_CLK_HALF: assert property (
    ptick && !ctrl.protocol_clock_select && !halted && !wr_ph |=> !ptick)
    else $error("Protocol clock not halved.");
  AST_MODE_LEGAL: assert property (mode_legal(current_mode_out))
    else $error("Current mode holds a reserved code.");
  AST_MODE_FOLLOW: assert property (
    !halted && mode_legal(ctrl.mode_request) |=> current_mode_out == $past(ctrl.mode_request))
    else $error("Current mode did not follow request.");
  AST_CAPTURE: assert property (
    rx_msg_done_in && !halted
    |=> rx_capture_trigger_out == $past(ctrl.rx_timestamp_capture_enable))
    else $error("Capture trigger wrong on receive.");
  AST_WINDOW: assert property (
    wr_ph && ph.addr == `CMBT_OFS_CTRL
    |=> filter_window_out == $past(hwdata_in[`CMBT_BIT_WINDOW]))
    else $error("Window select not written.");
  AST_ERRCNT: assert property (
    rd_go && ph.addr == `CMBT_OFS_ERRCNT |=> hrdata_out[15:0] == $past(errcnt))
    else $error("Error count read back wrong.");
  AST_TQ_GAP: assert property (time_quantum_tick_out |=> !time_quantum_tick_out)
    else $error("Quantum shorter than two protocol ticks.");

  COV_MODE: cover property (current_mode_out == CMBT_CONFIG ##[1:20]
    current_mode_out == CMBT_NORMAL);
  COV_ABORT: cover property (abort_all_transmits_out ##[1:50] !abort_all_transmits_out);
  COV_CAPTURE: cover property (rx_capture_trigger_out);
  COV_IRQ: cover property (irq_out ##1 !irq_out);
endmodule // cmbt_mode_timing

// >>> verilog/cmbt_pkg.sv
// Types shared by the CAN mode and bit-timing control block.
// Assumes the constants header sits in the include path.
package cmbt_pkg;
  // Operating modes, same code for request and readback.
  typedef enum logic [2:0] {
    CMBT_NORMAL     = 3'b000,
    CMBT_DISABLE    = 3'b001,
    CMBT_LOOPBACK   = 3'b010,
    CMBT_LISTEN     = 3'b011,
    CMBT_CONFIG     = 3'b100,
    CMBT_RSVD_5     = 3'b101,
    CMBT_RSVD_6     = 3'b110,
    CMBT_LISTEN_ALL = 3'b111
  } cmbt_mode_t;
  // Writable fields of the control register.
  typedef struct packed {
    logic       idle_stop_enable;
    logic       abort_all_transmits;
    logic       protocol_clock_select;
    cmbt_mode_t mode_request;
    logic       rx_timestamp_capture_enable;
    logic       window_select;
  } cmbt_ctrl_t;
  // Captured AHB address phase.
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } cmbt_ahb_ph_t;
endpackage : cmbt_pkg
